// ===== hw/uht_pkg.sv
// Package with timing constants, state codes and helpers for the upstream event timer.
package uht_pkg;

  // ----------------------------------------------------------------------------
  // Clock and counter sizing
  // ----------------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CNT_W   = 27;

  // ----------------------------------------------------------------------------
  // Times as programmed, short ones in ns and long ones in us
  // ----------------------------------------------------------------------------
  localparam int T_DETRST_NS      = 2500;
  localparam int T_FILTSE0_NS     = 2500;
  localparam int T_CHIRP_FILT_NS  = 2500;
  localparam int T_FS_CHIRP_US    = 2500;
  localparam int T_REVERT_US      = 3000;
  localparam int T_REV_SAMPLE_US  = 100;
  localparam int T_CHIRP_K_US     = 1000;
  localparam int T_CHIRP_END_US   = 7000;
  localparam int T_FALLBACK_US    = 1500;
  localparam int T_RECOVERY_US    = 1000;
  localparam int T_ADDR_US        = 50000;
  localparam int T_NODATA_US      = 50000;
  localparam int T_DATA_US        = 500000;
  localparam int T_LAST_US        = 50000;

  // ----------------------------------------------------------------------------
  // Bit-time figures; 6.5 bit times is held in tenths
  // ----------------------------------------------------------------------------
  localparam int FS_RATE_MHZ      = 12;
  localparam int HS_RATE_MHZ      = 480;
  localparam int FS_IPD_BITS      = 2;
  localparam int FS_RSP_TENTHS    = 65;
  localparam int HS_SAME_BITS     = 88;
  localparam int HS_OPP_BITS      = 8;
  localparam int CHIRP_PAIRS      = 3;

  // ----------------------------------------------------------------------------
  // Cycle counts: least times round up, longest times round down
  // ----------------------------------------------------------------------------
  localparam int DETRST_CYC       = (T_DETRST_NS * CLK_MHZ + 999) / 1000;
  localparam int FILTSE0_CYC      = (T_FILTSE0_NS * CLK_MHZ + 999) / 1000;
  localparam int CHIRP_FILT_CYC   = (T_CHIRP_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FS_CHIRP_CYC     = T_FS_CHIRP_US * CLK_MHZ;
  localparam int REVERT_CYC       = T_REVERT_US * CLK_MHZ;
  localparam int REV_SAMPLE_CYC   = T_REV_SAMPLE_US * CLK_MHZ;
  localparam int CHIRP_K_CYC      = T_CHIRP_K_US * CLK_MHZ;
  localparam int CHIRP_END_CYC    = T_CHIRP_END_US * CLK_MHZ;
  localparam int FALLBACK_CYC     = T_FALLBACK_US * CLK_MHZ;
  localparam int RECOVERY_CYC     = T_RECOVERY_US * CLK_MHZ;
  localparam int ADDR_CYC         = T_ADDR_US * CLK_MHZ;
  localparam int NODATA_CYC       = T_NODATA_US * CLK_MHZ;
  localparam int DATA_CYC         = T_DATA_US * CLK_MHZ;
  localparam int LAST_CYC         = T_LAST_US * CLK_MHZ;
  localparam int FS_IPD_CYC       = (FS_IPD_BITS * CLK_MHZ + FS_RATE_MHZ - 1) / FS_RATE_MHZ;
  localparam int FS_RSP_CYC       = (FS_RSP_TENTHS * CLK_MHZ) / (FS_RATE_MHZ * 10);
  localparam int HS_SAME_CYC      = (HS_SAME_BITS * CLK_MHZ + HS_RATE_MHZ - 1) / HS_RATE_MHZ;
  localparam int HS_OPP_CYC       = (HS_OPP_BITS * CLK_MHZ + HS_RATE_MHZ - 1) / HS_RATE_MHZ;

  // ----------------------------------------------------------------------------
  // Link states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_FS        = 3'b000,
    S_HS        = 3'b001,
    S_RESET     = 3'b010,
    S_REV_WAIT  = 3'b011,
    S_CHIRP     = 3'b100,
    S_WAIT_HOST = 3'b101,
    S_RECOVER   = 3'b110
  } uht_state_e;

  // True in the cycle in which a counter that started at zero has run n cycles.
  function automatic logic uht_hit(input logic [CNT_W-1:0] cnt, input int n);
    uht_hit = (cnt == CNT_W'(n - 1));
  endfunction : uht_hit

endpackage : uht_pkg

// ===== hw/uht_timer.sv
// Saturating cycle counter that restarts from zero on a clear.
`timescale 1ns/1ps

module uht_timer
  import uht_pkg::*;
(
  input  wire logic             sys_clk,  // System clock
  input  wire logic             rst_n,    // Asynchronous reset, active low
  input  wire logic             clk_en,   // Freezes the count while low
  input  wire logic             clear,    // Restart from zero
  output logic [CNT_W-1:0]      count_q   // Cycles since last clear
);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clk_en) begin
      if (clear) begin
        count_q <= '0;
      end else if (count_q != {CNT_W{1'b1}}) begin
        count_q <= count_q + CNT_W'(1);
      end
    end
  end

endmodule : uht_timer

// ===== hw/uht_upstream_timing.sv
// Upstream port event timing: reset detection, chirp handshake, packet gaps, request deadlines.
`timescale 1ns/1ps

// Functional notes
// RQ1: Non-HS hub flags reset after SE0 filter.
// RQ2: Ready for transactions within 10 ms.
// RQ3: Full-speed packets separated by two bits.
// RQ4: Full-speed response begins within 6.5 bits.
// RQ5: Address and no-data requests within 50 ms.
// RQ6: Non-final data packets within 500 ms each.
// RQ7: Final data packet within 50 ms.
// RQ8: Suspended hub filters SE0 before chirping.
// RQ9: Awake full-speed hub chirps after SE0 wait.
// RQ10: High-speed hub reverts after SE0 window.
// RQ11: Wait after revert, then sample line.
// RQ12: Chirp K lasts at least 1 ms.
// RQ13: Chirp K ends by 7 ms.
// RQ14: Host chirps seen, enter high speed promptly.
// RQ15: No host chirp, fall back to full speed.
// RQ16: High-speed gaps 88 same, 8 opposite.
// RQ17: Each chirp filtered 2.5 us before counting.
// RQ18: Counters restart when watched line changes.
// RQ19: One programmed constant inside each window.
module uht_upstream_timing
  import uht_pkg::*;
#(
  parameter int P_FS_CHIRP   = FS_CHIRP_CYC,  // RQ19
  parameter int P_REVERT     = REVERT_CYC,
  parameter int P_REV_SAMPLE = REV_SAMPLE_CYC,
  parameter int P_CHIRP_K    = CHIRP_K_CYC,
  parameter int P_FALLBACK   = FALLBACK_CYC,
  parameter int P_RECOVERY   = RECOVERY_CYC,
  parameter int P_ADDR       = ADDR_CYC,
  // The other two 50 ms limits follow the address limit, so shortening it shortens all three.
  parameter int P_NODATA     = P_ADDR + (NODATA_CYC - ADDR_CYC),
  parameter int P_DATA       = DATA_CYC,
  parameter int P_LAST       = P_ADDR + (LAST_CYC - ADDR_CYC)
)(
  input  wire logic sys_clk,        // System clock, 200 MHz
  input  wire logic rst_n,          // Asynchronous reset, active low
  input  wire logic clk_en,         // Freezes all state while low
  input  wire logic line_se0,       // Upstream line shows SE0
  input  wire logic line_j,         // Upstream line shows chirp J
  input  wire logic line_k,         // Upstream line shows chirp K
  input  wire logic suspended,      // Hub is suspended
  input  wire logic hs_capable,     // Hub may run at high speed
  input  wire logic rx_pkt_end,     // Pulse: received packet ended
  input  wire logic tx_pkt_start,   // Pulse: own packet starts
  input  wire logic tx_pkt_end,     // Pulse: own packet ended
  input  wire logic resp_expected,  // Received packet needs a response
  input  wire logic req_start,      // Pulse: standard request begins
  input  wire logic req_is_addr,    // Request assigns the address
  input  wire logic req_has_data,   // Request has a data stage
  input  wire logic req_last_next,  // Next data packet is the final one
  input  wire logic data_pkt_sent,  // Pulse: a data packet delivered
  input  wire logic req_done,       // Pulse: request completed
  output logic      bus_reset_q,    // Pulse: upstream reset recognised
  output logic      chirp_k_q,      // Drive chirp K upstream
  output logic      hs_mode_q,      // Operating at high speed
  output logic      ready_q,        // Ready to accept transactions
  output logic      tx_gap_ok,      // Inter-packet gap satisfied
  output logic      resp_late_q,    // Pulse: response deadline reached
  output logic      req_busy_q,     // Request deadline running
  output logic      req_late_q      // Pulse: request deadline reached
);

  // ----------------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------------
  uht_state_e         state_q, state_d;
  logic [CNT_W-1:0]   se0_cnt, st_cnt, flt_cnt, gap_cnt, req_cnt, req_limit_q;
  logic               j_prev_q, k_prev_q, expect_k_q;
  logic [1:0]         pairs_q;
  logic               chirp_hit, pairs_done, pkt_end, line_chg;
  logic               last_tx_q, resp_wait_q;

  assign pkt_end  = rx_pkt_end || tx_pkt_end;
  assign line_chg = (line_j != j_prev_q) || (line_k != k_prev_q);

  uht_timer u_se0 (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .clear(!line_se0),  // RQ18
                   .count_q(se0_cnt));
  uht_timer u_st  (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
                   .clear((state_d != state_q) || (state_q == S_RECOVER && line_se0)), .count_q(st_cnt));
  uht_timer u_flt (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
                   .clear(line_chg || state_q != S_WAIT_HOST), .count_q(flt_cnt));  // RQ18
  uht_timer u_gap (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .clear(pkt_end), .count_q(gap_cnt));
  uht_timer u_req (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .clear(req_start || data_pkt_sent),
                   .count_q(req_cnt));

  // ----------------------------------------------------------------------------
  // Reset and chirp handshake
  // ----------------------------------------------------------------------------
  // A chirp counts only once it has stood unchanged for the filter time.
  assign chirp_hit  = (state_q == S_WAIT_HOST) && uht_hit(flt_cnt, CHIRP_FILT_CYC) &&
                      (expect_k_q ? line_k : line_j);  // RQ17
  assign pairs_done = chirp_hit && !expect_k_q && (pairs_q == 2'(CHIRP_PAIRS - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_FS: begin
        if (line_se0 && !hs_capable && uht_hit(se0_cnt, DETRST_CYC)) begin
          state_d = S_RESET;  // RQ1
        end else if (line_se0 && hs_capable && suspended && uht_hit(se0_cnt, FILTSE0_CYC)) begin
          state_d = S_CHIRP;  // RQ8
        end else if (line_se0 && hs_capable && !suspended && uht_hit(se0_cnt, P_FS_CHIRP)) begin
          state_d = S_CHIRP;  // RQ9
        end
      end
      S_HS: begin
        if (line_se0 && uht_hit(se0_cnt, P_REVERT)) begin
          state_d = S_REV_WAIT;  // RQ10
        end
      end
      S_REV_WAIT: begin
        if (uht_hit(st_cnt, P_REV_SAMPLE)) begin
          state_d = line_se0 ? S_CHIRP : S_FS;  // RQ11
        end
      end
      S_CHIRP: begin
        if (uht_hit(st_cnt, P_CHIRP_K)) begin
          state_d = S_WAIT_HOST;  // RQ12 RQ13
        end
      end
      S_WAIT_HOST: begin
        if (pairs_done) begin
          state_d = S_HS;  // RQ14
        end else if (uht_hit(st_cnt, P_FALLBACK)) begin
          state_d = S_RESET;  // RQ15
        end
      end
      S_RESET: begin
        if (!line_se0) begin
          state_d = S_RECOVER;
        end
      end
      S_RECOVER: begin
        if (uht_hit(st_cnt, P_RECOVERY)) begin
          state_d = S_FS;  // RQ2
        end
      end
      default: state_d = S_FS;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= S_FS;
      hs_mode_q   <= 1'b0;
      chirp_k_q   <= 1'b0;
      bus_reset_q <= 1'b0;
      ready_q     <= 1'b0;
    end else if (clk_en) begin
      state_q     <= state_d;
      chirp_k_q   <= (state_d == S_CHIRP);  // RQ12
      hs_mode_q   <= (state_d == S_HS) || (state_q == S_HS && state_d == S_HS);  // RQ10 RQ14
      bus_reset_q <= (state_q == S_FS && (state_d == S_RESET || state_d == S_CHIRP)) ||
                     (state_q == S_REV_WAIT && state_d == S_CHIRP);
      if (state_d == S_RESET || state_d == S_CHIRP || state_d == S_REV_WAIT) begin
        ready_q <= 1'b0;
      end else if ((state_q == S_RECOVER && state_d == S_FS) || state_d == S_HS) begin
        ready_q <= 1'b1;  // RQ2
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      j_prev_q   <= 1'b0;
      k_prev_q   <= 1'b0;
      expect_k_q <= 1'b1;
      pairs_q    <= 2'b00;
    end else if (clk_en) begin
      j_prev_q <= line_j;
      k_prev_q <= line_k;
      if (state_q != S_WAIT_HOST) begin
        expect_k_q <= 1'b1;
        pairs_q    <= 2'b00;
      end else if (chirp_hit) begin
        expect_k_q <= !expect_k_q;
        if (!expect_k_q) begin
          pairs_q <= pairs_q + 2'b01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Inter-packet gaps and response deadline
  // ----------------------------------------------------------------------------
  // The gap timer is shared by both directions, so a gap is measured from whichever packet ended last.
  assign tx_gap_ok = !hs_mode_q ? (gap_cnt >= CNT_W'(FS_IPD_CYC - 1)) :  // RQ3
                     last_tx_q  ? (gap_cnt >= CNT_W'(HS_SAME_CYC - 1)) :  // RQ16
                                  (gap_cnt >= CNT_W'(HS_OPP_CYC - 1));  // RQ16

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_tx_q   <= 1'b0;
      resp_wait_q <= 1'b0;
      resp_late_q <= 1'b0;
    end else if (clk_en) begin
      if (pkt_end) begin
        last_tx_q <= tx_pkt_end;
      end
      resp_late_q <= resp_wait_q && !tx_pkt_start && uht_hit(gap_cnt, FS_RSP_CYC);  // RQ4
      if (rx_pkt_end && resp_expected && !hs_mode_q) begin
        resp_wait_q <= 1'b1;
      end else if (tx_pkt_start || uht_hit(gap_cnt, FS_RSP_CYC)) begin
        resp_wait_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Standard request deadlines
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_busy_q  <= 1'b0;
      req_late_q  <= 1'b0;
      req_limit_q <= '0;
    end else if (clk_en) begin
      req_late_q <= req_busy_q && !req_start && !data_pkt_sent && !req_done && (req_cnt == req_limit_q);
      if (req_start) begin
        req_busy_q <= 1'b1;
        if (req_has_data) begin
          req_limit_q <= req_last_next ? CNT_W'(P_LAST - 1) : CNT_W'(P_DATA - 1);  // RQ6 RQ7
        end else begin
          req_limit_q <= req_is_addr ? CNT_W'(P_ADDR - 1) : CNT_W'(P_NODATA - 1);  // RQ5
        end
      end else if (data_pkt_sent && req_busy_q) begin
        req_limit_q <= req_last_next ? CNT_W'(P_LAST - 1) : CNT_W'(P_DATA - 1);  // RQ6 RQ7
      end else if (req_done || (req_busy_q && req_cnt == req_limit_q)) begin
        req_busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  // Age of the reset sequence, counted from the start of the SE0 that led into chirp or revert handling.
  logic [CNT_W-1:0] seq_age_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_age_q <= '0;
    end else if (clk_en) begin
      seq_age_q <= (state_q == S_FS || state_q == S_HS) ? se0_cnt : seq_age_q + CNT_W'(1);
    end
  end

  det_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
    (clk_en && state_q == S_FS && !hs_capable && line_se0 && uht_hit(se0_cnt, DETRST_CYC)) |=> bus_reset_q)
    else $error("reset not flagged after SE0 filter");
  chirp_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
    $fell(chirp_k_q) |-> $past(st_cnt) == CNT_W'(P_CHIRP_K - 1))
    else $error("chirp K shorter than programmed");
  chirp_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ13
    chirp_k_q |-> seq_age_q < CNT_W'(CHIRP_END_CYC))
    else $error("chirp K still driven past deadline");
  revert_fs_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
    (clk_en && state_q == S_HS && line_se0 && uht_hit(se0_cnt, P_REVERT)) |=> !hs_mode_q && state_q == S_REV_WAIT)
    else $error("no revert to full speed");
  sample_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11
    ($past(state_q) == S_REV_WAIT && state_q != S_REV_WAIT) |-> $past(st_cnt) == CNT_W'(P_REV_SAMPLE - 1))
    else $error("line sampled at wrong time after revert");
  hs_enter_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
    (clk_en && pairs_done) |=> hs_mode_q && ready_q)
    else $error("high speed not entered after host chirps");
  fs_fallback_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
    (clk_en && state_q == S_WAIT_HOST && !pairs_done && uht_hit(st_cnt, P_FALLBACK)) |=> state_q == S_RESET && !hs_mode_q)
    else $error("no fallback after missing host chirp");
  filt_chirp_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ17
    (clk_en && state_q == S_WAIT_HOST && $changed(pairs_q) && pairs_q != 2'b00) |-> $past(flt_cnt) == CNT_W'(CHIRP_FILT_CYC - 1))
    else $error("chirp counted before filter time");
  fs_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ3
    (clk_en && pkt_end && !hs_mode_q) |=> !tx_gap_ok [*2])
    else $error("full-speed gap opened too early");
  resp_late_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ4
    resp_late_q |-> $past(gap_cnt) == CNT_W'(FS_RSP_CYC - 1))
    else $error("response deadline flagged at wrong time");
  req_late_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ5 RQ6 RQ7
    req_late_q |=> !req_busy_q || $past(req_start) || $past(data_pkt_sent))
    else $error("request still busy after deadline");
  reset_recover_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ2
    ($past(state_q) == S_RECOVER && state_q == S_FS) |-> ready_q && $past(st_cnt) == CNT_W'(P_RECOVERY - 1))
    else $error("recovery interval wrong");

  hs_path_c:   cover property (@(posedge sys_clk) disable iff (!rst_n) pairs_done && clk_en);
  fallback_c:  cover property (@(posedge sys_clk) disable iff (!rst_n) state_q == S_WAIT_HOST ##1 state_q == S_RESET);
  fs_reset_c:  cover property (@(posedge sys_clk) disable iff (!rst_n) bus_reset_q && !hs_capable);

endmodule : uht_upstream_timing

// ===== testbench/uht_host_model.sv
// Upstream host model that drives the decoded upstream line states.
`timescale 1ns/1ps

module uht_host_model (
  input  wire logic sys_clk,   // System clock
  output logic      line_se0,  // Upstream SE0
  output logic      line_j,    // Upstream chirp J
  output logic      line_k     // Upstream chirp K
);
  initial begin
    line_se0 = 1'b0;
    line_j   = 1'b0;
    line_k   = 1'b0;
  end

  // Holds one line state for n cycles; changes land only on the falling edge.
  task automatic hold(input logic se0, input logic j, input logic k, input int n);
    line_se0 = se0;
    line_j   = j;
    line_k   = k;
    repeat (n) @(negedge sys_clk);
  endtask : hold

  // Two chirps too short for the filter, then three full K-J pairs, then idle.
  task automatic chirp_seq(input int short_len);
    hold(1'b0, 1'b0, 1'b1, short_len);
    hold(1'b0, 1'b1, 1'b0, short_len);
    for (int i = 0; i < 6; i++) begin
      hold(1'b0, i[0], ~i[0], 520);
    end
    hold(1'b0, 1'b0, 1'b0, 1);
  endtask : chirp_seq
endmodule : uht_host_model

// ===== testbench/test_uht_upstream_timing.sv
// Self-checking bench for the upstream event timer with a queued event scoreboard.
`timescale 1ns/1ps

module test_uht_upstream_timing;
  import uht_pkg::*;

  typedef struct {int kind; int lo; int hi;} uht_note_s;

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        suspended = 1'b0, hs_capable = 1'b0, resp_expected = 1'b0;
  logic        rx_pkt_end = 1'b0, tx_pkt_start = 1'b0, tx_pkt_end = 1'b0, req_start = 1'b0;
  logic        req_is_addr = 1'b0, req_has_data = 1'b0, req_last_next = 1'b0;
  logic        data_pkt_sent = 1'b0, req_done = 1'b0;
  logic        line_se0, line_j, line_k;
  logic        bus_reset_q, chirp_k_q, hs_mode_q, ready_q, tx_gap_ok, resp_late_q, req_busy_q, req_late_q;
  logic [8:0]  prev_v = 9'h000;
  logic [31:0] seed = 32'h70a2_6b0a;
  logic [31:0] r;
  int          cyc = 0;
  int          mismatches = 0;
  int          total_checks = 0;
  uht_note_s   notes[$];

  uht_upstream_timing #(.P_REVERT(600), .P_CHIRP_K(200), .P_FALLBACK(4000), .P_RECOVERY(100),
    .P_ADDR(1000)) i_uht_upstream_timing (
    .sys_clk, .rst_n, .clk_en, .line_se0, .line_j, .line_k, .suspended, .hs_capable,
    .rx_pkt_end, .tx_pkt_start, .tx_pkt_end, .resp_expected, .req_start, .req_is_addr,
    .req_has_data, .req_last_next, .data_pkt_sent, .req_done, .bus_reset_q, .chirp_k_q,
    .hs_mode_q, .ready_q, .tx_gap_ok, .resp_late_q, .req_busy_q, .req_late_q);

  uht_host_model i_uht_host_model (.sys_clk, .line_se0, .line_j, .line_k);

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Event codes: 0 reset pulse, 1/2 chirp on/off, 3/4 high speed on/off, 5 ready,
  // 6 response late, 7 request late, 8 gap satisfied.
  task automatic note(input int kind, input int lo, input int hi);
    notes.push_back('{kind, cyc + lo, cyc + hi});
  endtask : note

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------------------
  // Watcher: every new event must match the oldest note, in kind and in time
  // ----------------------------------------------------------------------------
  always @(negedge sys_clk) begin
    logic [8:0] v;
    uht_note_s  n;
    v = {tx_gap_ok, req_late_q, resp_late_q, ready_q, ~hs_mode_q, hs_mode_q, ~chirp_k_q, chirp_k_q, bus_reset_q};
    for (int i = 0; i < 9; i++) begin
      if (rst_n && v[i] === 1'b1 && prev_v[i] === 1'b0) begin
        if (notes.size() == 0) begin
          check("unexpected event", i, 99);
        end else begin
          n = notes.pop_front();
          check("event kind", i, n.kind);
          check("event time", 32'(cyc >= n.lo && cyc <= n.hi), 1);
        end
      end
    end
    prev_v = v;
  end

  initial begin
    repeat (75000) @(posedge sys_clk);
    mismatches++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    results();
  end

  initial begin
    step(10);
    rst_n = 1'b1;
    note(8, 30, 40);
    i_uht_host_model.hold(1'b1, 1'b0, 1'b0, 400);
    i_uht_host_model.hold(1'b0, 1'b0, 1'b0, 1);
    note(0, 500, 504);
    note(5, 900, 906);
    i_uht_host_model.hold(1'b1, 1'b0, 1'b0, 800);
    i_uht_host_model.hold(1'b0, 1'b0, 1'b0, 300);
    $display("test reset detect done");
    hs_capable = 1'b1;
    suspended  = 1'b1;
    r = 100 + rnd() % 300;
    note(0, 500, 504);
    note(1, 500, 504);
    note(2, 700, 706);
    note(3, 705 + 2 * r + 3100, 705 + 2 * r + 3106);
    note(5, 705 + 2 * r + 3100, 705 + 2 * r + 3106);
    i_uht_host_model.hold(1'b1, 1'b0, 1'b0, 705);
    i_uht_host_model.chirp_seq(r);
    step(300);
    note(8, HS_SAME_CYC - 1, HS_SAME_CYC + 1);
    pulse(tx_pkt_end);
    step(60);
    note(8, HS_OPP_CYC - 1, HS_OPP_CYC + 1);
    pulse(rx_pkt_end);
    step(20);
    $display("test chirp handshake done");
    suspended = 1'b0;
    note(4, 600, 604);
    note(0, REV_SAMPLE_CYC + 600, REV_SAMPLE_CYC + 608);
    note(1, REV_SAMPLE_CYC + 600, REV_SAMPLE_CYC + 608);
    note(2, REV_SAMPLE_CYC + 800, REV_SAMPLE_CYC + 810);
    note(5, REV_SAMPLE_CYC + 4895, REV_SAMPLE_CYC + 4915);
    i_uht_host_model.hold(1'b1, 1'b0, 1'b0, REV_SAMPLE_CYC + 805);
    i_uht_host_model.hold(1'b0, 1'b0, 1'b0, 4200);
    $display("test revert and fallback done");
    i_uht_host_model.hold(1'b1, 1'b0, 1'b0, FILTSE0_CYC + 100);
    i_uht_host_model.hold(1'b0, 1'b0, 1'b0, 1);
    resp_expected = 1'b1;
    note(8, 33, 37);
    note(6, 107, 111);
    pulse(rx_pkt_end);
    step(200);
    pulse(rx_pkt_end);
    step(1 + rnd() % 20);
    pulse(tx_pkt_start);
    step(5);
    note(8, 33, 37);
    pulse(tx_pkt_end);
    step(200);
    $display("test packet gaps done");
    r = rnd();
    req_is_addr = r[0];
    note(7, 1019, 1025);
    pulse(req_start);
    step(100);
    clk_en = 1'b0;
    step(20);
    clk_en = 1'b1;
    step(1000);
    req_has_data = 1'b1;
    note(7, 9000, 9005);
    pulse(req_start);
    step(3999);
    pulse(data_pkt_sent);
    step(3999);
    req_last_next = 1'b1;
    pulse(data_pkt_sent);
    step(1100);
    pulse(req_start);
    step(500);
    check("busy running", req_busy_q, 1);
    pulse(req_done);
    step(5500);
    check("busy after done", req_busy_q, 0);
    check("notes left", notes.size(), 0);
    $display("test request deadlines done");
    results();
  end
endmodule : test_uht_upstream_timing
